// ==== hw/codec_reg_device.sv ====
// codec register bank: pin reuse, clock selection, paging, coef 0
// assumes link requests held until ack; pins synchronous to clk
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "codec_regs_defs.svh"
module codec_reg_device
   import codec_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   ctrl_link_if.dev link,
   input wire logic busSelect,
   input wire logic multiFunctionPin0In,
   input wire logic multiFunctionPin1In,
   input wire logic multiFunctionPin3In,
   input wire logic sclPinIn,
   output logic sclPinOut,
   output logic sclPinOe,
   output logic multiFunctionPin2Out,
   output logic multiFunctionPin2Oe,
   output logic serialDataInEn,
   output logic serialDataIn,
   output logic converterCoreClockSel,
   output logic [1:0] dividerInputClockSel,
   output logic [1:0] pllReferenceInputSel,
   output logic [4:0] pllDivN,
   output logic [15:0] effectsCoef0,
   output logic activePage
);
   dev_state_s s_q;
   dev_state_s s_d;
   logic take;
   logic hiWe;
   logic loWe;
   logic [7:0] coefHi;
   logic [7:0] coefLo;

   // ======================================
   // pll divider decode
   function automatic logic [4:0] pllDivide(input logic [3:0] code);
      logic [4:0] n;
      n = {1'b0, code};
      if (code == 4'h0) begin
         n = 5'h10;
      end else if (code == 4'h1) begin
         n = 5'h11;
      end
      return n;
   endfunction

   // ======================================
   // link write strobes for the coefficient pair
   assign take = link.req && !s_q.ack;
   assign hiWe = take && link.wr && s_q.page
      && link.addr == `REG_COEF0_HI;
   assign loWe = take && link.wr && s_q.page
      && link.addr == `REG_COEF0_LO;

   coef_pair_reg i_coef_pair_reg (
      .clk(clk),
      .rst(rst),
      .hiWe(hiWe),
      .loWe(loWe),
      .wdata(link.wdata),
      .hi(coefHi),
      .lo(coefLo),
      .coef(effectsCoef0)
   );

   // ======================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      // straps caught once after reset release
      if (!s_q.strapDone) begin
         s_d.straps = {multiFunctionPin1In, multiFunctionPin0In};
         s_d.strapDone = 1'b1;
      end
      // pin sampling
      // pinA holds d7-d1: scl mode at [2:1], scl drive value at [0]
      if (s_q.pinA[2:1] == `GPIO_MODE_IN && busSelect) begin
         s_d.sclIn = sclPinIn;
      end
      if (s_q.pinB[5] && !busSelect) begin
         s_d.mfp3In = multiFunctionPin3In;
      end
      // link access
      if (take) begin
         s_d.ack = 1'b1;
         s_d.rdata = 8'h00;
         if (link.addr == `REG_PAGE_SEL) begin
            s_d.rdata = {7'h00, s_q.page};
            if (link.wr) begin
               s_d.page = link.wdata[0];
            end
         end else if (s_q.page) begin
            case (link.addr)
               `REG_COEF0_HI: begin
                  s_d.rdata = coefHi;
               end
               `REG_COEF0_LO: begin
                  s_d.rdata = coefLo;
               end
               default: begin
                  s_d.rdata = 8'h00;
               end
            endcase
         end else begin
            case (link.addr)
               `REG_PIN_A: begin
                  s_d.rdata = {s_q.pinA, s_q.sclIn};
                  if (link.wr) begin
                     s_d.pinA = link.wdata[7:1];
                  end
               end
               `REG_PIN_B: begin
                  s_d.rdata = {s_q.straps[1], s_q.straps[0],
                     s_q.pinB[5:4], s_q.mfp3In,
                     s_q.pinB[2:0]};
                  if (link.wr) begin
                     s_d.pinB = {link.wdata[5:4], 1'b0,
                        link.wdata[2:0]};
                  end
               end
               `REG_CLK_GEN: begin
                  s_d.rdata = s_q.clkGen;
                  if (link.wr) begin
                     // reserved select codes leave the field as it was
                     if (link.wdata[7:6] != `SEL_RESERVED) begin
                        s_d.clkGen[7:6] = link.wdata[7:6];
                     end
                     if (link.wdata[5:4] != `SEL_RESERVED) begin
                        s_d.clkGen[5:4] = link.wdata[5:4];
                     end
                     s_d.clkGen[3:0] = link.wdata[3:0];
                  end
               end
               default: begin
                  // includes 103-127: zero, writes dropped
                  s_d.rdata = 8'h00;
               end
            endcase
         end
      end
      // pin and clock control outputs
      s_d.sclOut = 1'b0;
      s_d.sclOe = busSelect && s_q.pinA[2:1] == `GPIO_MODE_OUT
         && !s_q.pinA[0];
      s_d.mfp2Oe = s_q.pinB[2] && !busSelect;
      s_d.mfp2Out = s_q.pinB[1];
      s_d.sdEn = s_q.pinB[4] && !busSelect;
      s_d.sdIn = s_q.pinB[4] && !busSelect
         && multiFunctionPin3In;
      s_d.coreSel = s_q.pinB[0];
      s_d.divSel = s_q.clkGen[7:6];
      s_d.refSel = s_q.clkGen[5:4];
      s_d.pllN = pllDivide(s_q.clkGen[3:0]);
      if (rst) begin
         s_d = '0;
         s_d.clkGen = `CLK_GEN_RESET;
         s_d.pllN = pllDivide(s_d.clkGen[3:0]);
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // ======================================
   // outputs
   assign link.ack = s_q.ack;
   assign link.rdata = s_q.rdata;
   assign sclPinOut = s_q.sclOut;
   assign sclPinOe = s_q.sclOe;
   assign multiFunctionPin2Out = s_q.mfp2Out;
   assign multiFunctionPin2Oe = s_q.mfp2Oe;
   assign serialDataInEn = s_q.sdEn;
   assign serialDataIn = s_q.sdIn;
   assign converterCoreClockSel = s_q.coreSel;
   assign dividerInputClockSel = s_q.divSel;
   assign pllReferenceInputSel = s_q.refSel;
   assign pllDivN = s_q.pllN;
   assign activePage = s_q.page;
endmodule

// ==== hw/codec_regs_defs.svh ====
// constants for the codec register bank and its host controller
// assumes 7-bit register numbers on the link and byte-wide data
// Functional notes
// - scl output: d1 zero drives low, one releases
// - d0 reads scl level as input
// - d7/d6 report address straps caught at reset
// - d5 enables pin 3 as general input
// - d4 enables pin 3 as serial data
// - d3 reads pin 3 level as input
// - d2 enables pin 2 as general output
// - pin 2 output follows bit d1
// - d0 picks core clock: pll or divider
// - register b d7-d1 act only two-wire; d7/d6 straps read back with busSelect high too
// - divider input field; code 11 never written
// - pll reference field; code 11 never written
// - pll n: 0 is 16, 1 is 17
// - page 0 regs 103-127 read zero, unwritten
// - page bit d0 selects active page
// - page register works on both pages
// - host writes zeros to page bits d7-d1
// - host reads page bit back after write
// - coefficient is 16-bit two's complement, resets zero
// - host writes upper byte then lower byte
// - register a d7-d2 act only four-wire
`ifndef CODEC_REGS_DEFS_SVH
`define CODEC_REGS_DEFS_SVH
// ======================================
// link register numbers
`define REG_PAGE_SEL 7'h00
`define REG_COEF0_HI 7'h01
`define REG_COEF0_LO 7'h02
`define REG_PIN_A 7'h64
`define REG_PIN_B 7'h65
`define REG_CLK_GEN 7'h66
`define REG_RSVD_FIRST 7'h67
// ======================================
// field codes and reset values
`define SEL_RESERVED 2'h3
`define GPIO_MODE_IN 2'h1
`define GPIO_MODE_OUT 2'h2
`define CLK_GEN_RESET 8'h02
// ======================================
// host controller apb map
`define HOST_CMD 8'h00
`define HOST_COEF 8'h04
`define HOST_STAT 8'h08
`define CMD_WR_BIT 16
`define COEF_ADDR_LSB 16
`endif

// ==== hw/codec_regs_pkg.sv ====
// types shared by the codec register bank and its host controller
// assumes codec_regs_defs.svh is compiled alongside
package codec_regs_pkg;
   typedef enum logic [2:0] {
      HOST_IDLE = 3'b001,
      HOST_XFER = 3'b010,
      HOST_GAP = 3'b100
   } host_state_e;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic [15:0] coef;
   } coef_state_s;

   typedef struct packed {
      logic page;
      logic [6:0] pinA;
      logic sclIn;
      logic [1:0] straps;
      logic strapDone;
      logic [5:0] pinB;
      logic mfp3In;
      logic [7:0] clkGen;
      logic ack;
      logic [7:0] rdata;
      logic sclOut;
      logic sclOe;
      logic mfp2Out;
      logic mfp2Oe;
      logic sdEn;
      logic sdIn;
      logic coreSel;
      logic [1:0] divSel;
      logic [1:0] refSel;
      logic [4:0] pllN;
   } dev_state_s;

   typedef struct packed {
      host_state_e st;
      logic req;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic pendLo;
      logic [7:0] loByte;
      logic readBack;
      logic page;
      logic refused;
      logic [7:0] lastRd;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } host_state_s;
endpackage

// ==== hw/ctrl_link_if.sv ====
// register access link between host controller and codec bank
// assumes both ends share clk; req held until ack pulse
`timescale 1ns/100ps
interface ctrl_link_if;
   logic req;
   logic wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input req, input wr, input addr, input wdata,
      output ack, output rdata);
   modport host (output req, output wr, output addr, output wdata,
      input ack, input rdata);
endinterface

// ==== hw/coef_pair_reg.sv ====
// coefficient byte pair with upper byte held until lower byte write
// assumes one write strobe per cycle at most
`timescale 1ns/100ps
module coef_pair_reg
   import codec_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hiWe,
   input wire logic loWe,
   input wire logic [7:0] wdata,
   output logic [7:0] hi,
   output logic [7:0] lo,
   output logic [15:0] coef
);
   coef_state_s s_q;
   coef_state_s s_d;

   always_comb begin
      s_d = s_q;
      if (hiWe) begin
         s_d.hi = wdata;
      end
      if (loWe) begin
         s_d.lo = wdata;
         s_d.coef = {s_q.hi, wdata};
      end
      if (rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign hi = s_q.hi;
   assign lo = s_q.lo;
   assign coef = s_q.coef;
endmodule

// ==== hw/codec_reg_host.sv ====
// host controller: apb registers drive codec link accesses
// assumes the bank answers each held request with one ack pulse
`timescale 1ns/100ps
`include "codec_regs_defs.svh"
module codec_reg_host
   import codec_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   ctrl_link_if.host link
);
   host_state_s s_q;
   host_state_s s_d;
   logic wrEn;
   logic [6:0] cAddr;
   logic [7:0] cData;
   logic cWr;
   logic busy;

   assign wrEn = psel && penable && pready && pwrite;
   assign cAddr = pwdata[6:0];
   assign cData = pwdata[15:8];
   assign cWr = pwdata[`CMD_WR_BIT];
   assign busy = s_q.st != HOST_IDLE;

   always_comb begin
      s_d = s_q;
      // ======================================
      // apb slave, one wait-free access phase
      s_d.pready = psel && !penable;
      if (psel && !penable) begin
         case (paddr)
            `HOST_STAT: begin
               s_d.prdata = {16'h0000, s_q.lastRd, 5'h00, s_q.page,
                  s_q.refused, busy};
            end
            default: begin
               s_d.prdata = 32'h0000_0000;
            end
         endcase
      end
      // ======================================
      // command acceptance
      if (wrEn && paddr == `HOST_CMD) begin
         if (busy) begin
            s_d.refused = 1'b1;
         end else if (cWr && !s_q.page && cAddr >= `REG_RSVD_FIRST) begin
            s_d.refused = 1'b1;
         end else if (cWr && !s_q.page && cAddr == `REG_CLK_GEN
            && (cData[7:6] == `SEL_RESERVED
            || cData[5:4] == `SEL_RESERVED)) begin
            s_d.refused = 1'b1;
         end else begin
            s_d.refused = 1'b0;
            s_d.st = HOST_XFER;
            s_d.req = 1'b1;
            s_d.wr = cWr;
            s_d.addr = cAddr;
            s_d.wdata = cData;
            if (cAddr == `REG_PAGE_SEL) begin
               s_d.wdata = {7'h00, cData[0]};
               s_d.readBack = cWr;
            end
         end
      end else if (wrEn && paddr == `HOST_COEF) begin
         if (busy) begin
            s_d.refused = 1'b1;
         end else begin
            s_d.refused = 1'b0;
            s_d.st = HOST_XFER;
            s_d.req = 1'b1;
            s_d.wr = 1'b1;
            s_d.addr = pwdata[`COEF_ADDR_LSB +: 7];
            s_d.wdata = pwdata[15:8];
            s_d.loByte = pwdata[7:0];
            s_d.pendLo = 1'b1;
         end
      end
      // ======================================
      // link sequencer
      case (s_q.st)
         HOST_IDLE: begin
         end
         HOST_XFER: begin
            if (link.ack) begin
               s_d.req = 1'b0;
               s_d.lastRd = link.rdata;
               if (!s_q.wr && s_q.addr == `REG_PAGE_SEL) begin
                  s_d.page = link.rdata[0];
               end
               if (s_q.pendLo) begin
                  s_d.pendLo = 1'b0;
                  s_d.addr = s_q.addr + 7'h01;
                  s_d.wdata = s_q.loByte;
                  s_d.st = HOST_GAP;
               end else if (s_q.readBack) begin
                  s_d.readBack = 1'b0;
                  s_d.wr = 1'b0;
                  s_d.st = HOST_GAP;
               end else begin
                  s_d.st = HOST_IDLE;
               end
            end
         end
         HOST_GAP: begin
            s_d.req = 1'b1;
            s_d.st = HOST_XFER;
         end
         default: begin
            s_d.st = HOST_IDLE;
            s_d.req = 1'b0;
         end
      endcase
      if (rst) begin
         s_d = '0;
         s_d.st = HOST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign link.req = s_q.req;
   assign link.wr = s_q.wr;
   assign link.addr = s_q.addr;
   assign link.wdata = s_q.wdata;
endmodule

// ==== testbench/pin_clock_page_control_regs_properties.sv ====
// link checker for the codec register bank and its host controller
// assumes it watches the ctrl_link_if signals on the shared clk
`timescale 1ns/100ps
module pin_clock_page_control_regs_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic wr,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   // ======================================
   // shadow of page, clock control and upper coefficient byte
   logic page_q;
   logic [7:0] clkGen_q;
   logic [7:0] coefHi_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         page_q <= 1'b0;
         clkGen_q <= 8'h02;
         coefHi_q <= 8'h00;
      end else if (ack && wr) begin
         if (addr == 7'h00)
            page_q <= wdata[0];
         if (!page_q && addr == 7'h66) begin
            if (wdata[7:6] != 2'h3)
               clkGen_q[7:6] <= wdata[7:6];
            if (wdata[5:4] != 2'h3)
               clkGen_q[5:4] <= wdata[5:4];
            clkGen_q[3:0] <= wdata[3:0];
         end
         if (page_q && addr == 7'h01)
            coefHi_q <= wdata;
      end
   end

   // ======================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ack_after_req:
      assert property ($rose(req) |=> ack)
      else $error("link ack missing after request");
   a_ack_single_pulse:
      assert property (ack |=> !ack && !req)
      else $error("link ack or request stayed high");
   a_request_held:
      assert property (req && !ack |=> req && $stable(addr) && $stable(wr)
         && $stable(wdata))
      else $error("link request changed before ack");
   a_reserved_read_zero:
      assert property (ack && !wr && !page_q && addr >= 7'h67 |->
         rdata == 8'h00)
      else $error("reserved register read not zero");
   a_reserved_no_write:
      assert property (req && wr && !page_q |-> addr < 7'h67)
      else $error("write reached reserved register");
   a_page_reads_back:
      assert property (ack && !wr && addr == 7'h00 |->
         rdata == {7'h00, page_q})
      else $error("page register read mismatch");
   a_page_zero_bits:
      assert property (req && wr && addr == 7'h00 |-> wdata[7:1] == 7'h00)
      else $error("page write with upper bits set");
   a_page_confirm_read:
      assert property (ack && wr && addr == 7'h00 |->
         ##[1:4] (req && !wr && addr == 7'h00))
      else $error("no page read-back after page write");
   a_clock_gen_read:
      assert property (ack && !wr && !page_q && addr == 7'h66 |->
         rdata == clkGen_q)
      else $error("clock control read mismatch");
   a_no_reserved_select:
      assert property (req && wr && !page_q && addr == 7'h66 |->
         wdata[7:6] != 2'h3 && wdata[5:4] != 2'h3)
      else $error("reserved clock select code written");
   a_coef_upper_first:
      assert property (ack && wr && page_q && addr == 7'h01 |->
         ##[1:4] (req && wr && addr == 7'h02))
      else $error("lower coefficient byte not written after upper");
   a_coef_upper_read:
      assert property (ack && !wr && page_q && addr == 7'h01 |->
         rdata == coefHi_q)
      else $error("upper coefficient byte read mismatch");
endmodule

// ==== testbench/pin_clock_page_control_regs_tb_top.sv ====
// top bench: apb stimulus into host, host and bank joined by the link
// assumes the design files and codec_regs_defs.svh are compiled first
`timescale 1ns/100ps
`include "codec_regs_defs.svh"
module pin_clock_page_control_regs_tb_top;
   // ======================================
   // signals and instances
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic busSelect, pin0In, pin1In, pin3In, sclIn, sclPinOut, sclPinOe;
   logic pin2Out, pin2Oe, sdEn, sdIn, coreSel, page;
   logic [1:0] divSel, refSel;
   logic [4:0] pllN;
   logic [15:0] coef;
   int n_errors, checks;

   ctrl_link_if i_ctrl_link_if();
   codec_reg_host i_codec_reg_host (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(i_ctrl_link_if));
   codec_reg_device i_codec_reg_device (.clk(clk), .rst(rst),
      .link(i_ctrl_link_if), .busSelect(busSelect),
      .multiFunctionPin0In(pin0In), .multiFunctionPin1In(pin1In),
      .multiFunctionPin3In(pin3In), .sclPinIn(sclIn), .sclPinOut(sclPinOut),
      .sclPinOe(sclPinOe), .multiFunctionPin2Out(pin2Out),
      .multiFunctionPin2Oe(pin2Oe), .serialDataInEn(sdEn),
      .serialDataIn(sdIn), .converterCoreClockSel(coreSel),
      .dividerInputClockSel(divSel), .pllReferenceInputSel(refSel),
      .pllDivN(pllN), .effectsCoef0(coef), .activePage(page));
   pin_clock_page_control_regs_properties props (.clk(clk), .rst(rst),
      .req(i_ctrl_link_if.req), .wr(i_ctrl_link_if.wr),
      .addr(i_ctrl_link_if.addr), .wdata(i_ctrl_link_if.wdata),
      .ack(i_ctrl_link_if.ack), .rdata(i_ctrl_link_if.rdata));

   // ======================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic poll(output logic [31:0] st);
      do begin
         apb(1'b0, `HOST_STAT, 32'h0, st);
      end while (st[0] !== 1'b0);
   endtask

   task automatic cmd(input logic w, input logic [6:0] r,
      input logic [7:0] d, output logic [31:0] st);
      apb(1'b1, `HOST_CMD, {15'h0, w, d, 1'b0, r}, st);
      poll(st);
   endtask

   task automatic rd(input logic [6:0] r, output logic [7:0] v);
      logic [31:0] st;
      cmd(1'b0, r, 8'h00, st);
      v = st[15:8];
   endtask

   task automatic end_of_test;
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ======================================
   // scenarios
   task automatic t_reset_straps;
      logic [7:0] v;
      chk("pllDivN", 32'd2, 32'(pllN));
      chk("effectsCoef0", 32'h0, 32'(coef));
      pin0In <= 1'b1;
      pin1In <= 1'b0;
      rd(`REG_CLK_GEN, v);
      chk("clkGen", 32'h02, 32'(v));
      rd(`REG_PIN_B, v);
      chk("straps", 32'h2, 32'(v[7:6]));
   endtask

   task automatic t_clock_gen;
      logic [3:0] nCode[4] = '{4'h0, 4'h1, 4'hF, 4'h2};
      int nVal[4] = '{16, 17, 15, 2};
      logic [1:0] dv, rf;
      logic [31:0] st;
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         dv = 2'(i % 3);
         rf = 2'((i + 1) % 3);
         cmd(1'b1, `REG_CLK_GEN, {dv, rf, nCode[i]}, st);
         chk("divSel", 32'(dv), 32'(divSel));
         chk("refSel", 32'(rf), 32'(refSel));
         chk("pllDivN", 32'(nVal[i]), 32'(pllN));
      end
      cmd(1'b1, `REG_CLK_GEN, 8'hC2, st);
      chk("refusedDiv", 32'h1, 32'(st[1]));
      cmd(1'b1, `REG_CLK_GEN, 8'h32, st);
      chk("refusedRef", 32'h1, 32'(st[1]));
      rd(`REG_CLK_GEN, v);
      chk("clkGen", 32'h12, 32'(v));
   endtask

   task automatic t_pin_b;
      logic [31:0] st;
      logic [7:0] v;
      cmd(1'b1, `REG_PIN_B, 8'h27, st);
      chk("pin2Oe", 32'h1, 32'(pin2Oe));
      chk("pin2Out", 32'h1, 32'(pin2Out));
      chk("coreSel", 32'h1, 32'(coreSel));
      chk("sdEn", 32'h0, 32'(sdEn));
      pin3In <= 1'b1;
      rd(`REG_PIN_B, v);
      chk("pin3Read", 32'h1, 32'(v[3]));
      pin3In <= 1'b0;
      rd(`REG_PIN_B, v);
      chk("pin3Read", 32'h0, 32'(v[3]));
      cmd(1'b1, `REG_PIN_B, 8'h15, st);
      chk("sdEn", 32'h1, 32'(sdEn));
      chk("pin2Out", 32'h0, 32'(pin2Out));
      pin3In <= 1'b1;
      rd(`REG_PIN_B, v);
      chk("pin3Held", 32'h0, 32'(v[3]));
      chk("sdIn", 32'h1, 32'(sdIn));
      busSelect <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pin2Oe", 32'h0, 32'(pin2Oe));
      chk("sdEn", 32'h0, 32'(sdEn));
      chk("coreSel", 32'h1, 32'(coreSel));
   endtask

   task automatic t_pin_a;
      logic [31:0] st;
      logic [7:0] v;
      cmd(1'b1, `REG_PIN_A, 8'h08, st);
      chk("sclPinOe", 32'h1, 32'(sclPinOe));
      chk("sclPinOut", 32'h0, 32'(sclPinOut));
      cmd(1'b1, `REG_PIN_A, 8'h0A, st);
      chk("sclPinOe", 32'h0, 32'(sclPinOe));
      cmd(1'b1, `REG_PIN_A, 8'h04, st);
      rd(`REG_PIN_A, v);
      chk("sclRead", 32'h1, 32'(v[0]));
      sclIn <= 1'b0;
      rd(`REG_PIN_A, v);
      chk("sclRead", 32'h0, 32'(v[0]));
      sclIn <= 1'b1;
      cmd(1'b1, `REG_PIN_A, 8'h08, st);
      busSelect <= 1'b0;
      repeat (3) @(posedge clk);
      chk("sclPinOe", 32'h0, 32'(sclPinOe));
   endtask

   task automatic t_page_coef;
      logic [31:0] st;
      logic [7:0] v;
      cmd(1'b1, `REG_PAGE_SEL, 8'h01, st);
      chk("activePage", 32'h1, 32'(page));
      chk("statPage", 32'h1, 32'(st[2]));
      apb(1'b1, `HOST_COEF, {9'h0, `REG_COEF0_HI, 16'h8001}, st);
      poll(st);
      chk("effectsCoef0", 32'h8001, 32'(coef));
      apb(1'b1, `HOST_COEF, {9'h0, `REG_COEF0_HI, 16'h7FFF}, st);
      poll(st);
      chk("effectsCoef0", 32'h7FFF, 32'(coef));
      rd(`REG_COEF0_HI, v);
      chk("coefHi", 32'h7F, 32'(v));
      cmd(1'b1, `REG_PAGE_SEL, 8'h00, st);
      chk("activePage", 32'h0, 32'(page));
      chk("statPage", 32'h0, 32'(st[2]));
      rd(`REG_RSVD_FIRST, v);
      chk("reserved67", 32'h0, 32'(v));
      rd(7'h7F, v);
      chk("reserved7F", 32'h0, 32'(v));
      cmd(1'b1, 7'h70, 8'h5A, st);
      chk("refusedRsvd", 32'h1, 32'(st[1]));
      apb(1'b0, 8'h0C, 32'h0, st);
      chk("unmapped", 32'h0, st);
      chk("pslverr", 32'h0, 32'(pslverr));
   endtask

   // ======================================
   // clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, busSelect, pin0In, pin3In} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pin1In = 1'b1;
      sclIn = 1'b1;
      n_errors = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset_straps();
      t_clock_gen();
      t_pin_b();
      t_pin_a();
      t_page_coef();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule
